//--- inc/iss_pkg.sv
package iss_pkg;
	localparam int NUM_LINES = 16;
	localparam int FIRST_SEL_LINE = 4;
	localparam int SEL_W = 5;
	localparam int NUM_CODES = 17;
	// register byte addresses
	localparam logic [31:0] ADDR_SEL_HIGH = 32'h019C0000;
	localparam logic [31:0] ADDR_SEL_LOW = 32'h019C0004;
	localparam logic [31:0] ADDR_CTRL = 32'h019C0008;
	localparam logic [31:0] ADDR_LINE_EN = 32'h019C000C;
	localparam logic [31:0] ADDR_STATUS = 32'h019C0010;
	localparam logic [31:0] ADDR_MASK = 32'h019C0014;
	// selector field low bit positions, same for both registers
	localparam int FIELD_POS [6] = '{0, 5, 10, 16, 21, 26};
	localparam logic [31:0] SEL_WMASK = 32'h7FFF7FFF;
	localparam logic [31:0] SEL_LOW_RESET = {1'h0, 5'h09, 5'h08, 5'h07, 1'h0, 5'h06, 5'h05, 5'h04};
	localparam logic [31:0] SEL_HIGH_RESET = {1'h0, 5'h02, 5'h01, 5'h00, 1'h0, 5'h0B, 5'h0A, 5'h03};
	// control register fields
	localparam int CTRL_GIE_BIT = 0;
	localparam int CTRL_POL_LSB = 4;
	// selector codes
	localparam logic [4:0] CODE_NONE = 5'h00;
	localparam logic [4:0] CODE_TIMER0 = 5'h01;
	localparam logic [4:0] CODE_TIMER1 = 5'h02;
	localparam logic [4:0] CODE_MEMORY = 5'h03;
	localparam logic [4:0] CODE_GPIO4 = 5'h04;
	localparam logic [4:0] CODE_XFER_DONE = 5'h08;
	localparam logic [4:0] CODE_EMU_DMA = 5'h09;
	localparam logic [4:0] CODE_EMU_RX = 5'h0A;
	localparam logic [4:0] CODE_EMU_TX = 5'h0B;
	localparam logic [4:0] CODE_SER0_TX = 5'h0C;
	localparam logic [4:0] CODE_GPIO0 = 5'h10;
endpackage

//--- inc/iss_edge_if.sv
`timescale 1ns/10ps
interface iss_edge_if;
	logic [3:0] pin;
	logic [3:0] polarity;
	logic [3:0] event_pulse;
	modport src (output pin, output polarity, input event_pulse);
	modport det (input pin, input polarity, output event_pulse);
endinterface

//--- rtl/iss_pin_edge.sv
`timescale 1ns/10ps
module iss_pin_edge (
	input wire logic clock_i,
	input wire logic srst_i,
	iss_edge_if.det edge_if
);
	typedef struct packed {
		logic [3:0] prev;
		logic [3:0] pulse;
	} iss_edge_state_type;

	iss_edge_state_type state_q;
	iss_edge_state_type state_d;

	always_comb begin
		state_d = state_q;
		state_d.prev = edge_if.pin;
		// polarity 0 takes a rising edge, 1 a falling edge
		for (int i = 0; i < 4; i++) begin
			if (edge_if.polarity[i]) begin
				state_d.pulse[i] = state_q.prev[i] & ~edge_if.pin[i];
			end else begin
				state_d.pulse[i] = ~state_q.prev[i] & edge_if.pin[i];
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign edge_if.event_pulse = state_q.pulse;

	property p_edge_once;
		@(posedge clock_i) disable iff (srst_i)
		edge_if.event_pulse[0] |=> !edge_if.event_pulse[0];
	endproperty
	a_edge_once: assert property (p_edge_once)
		else $error("pin event longer than one cycle");
endmodule

//--- rtl/iss_top.sv
`timescale 1ns/10ps
module iss_top (
	input wire logic clock_i,
	input wire logic srst_i,
	input wire logic [31:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	input wire logic reset_event_i,
	input wire logic nmi_event_i,
	input wire logic timer0_event_i,
	input wire logic timer1_event_i,
	input wire logic memory_interface_event_i,
	input wire logic [3:0] external_irq_pin_i,
	input wire logic transfer_engine_done_event_i,
	input wire logic emulation_dma_event_i,
	input wire logic emulation_rx_event_i,
	input wire logic emulation_tx_event_i,
	input wire logic serial0_transmit_event_i,
	input wire logic serial0_receive_event_i,
	input wire logic serial1_transmit_event_i,
	input wire logic serial1_receive_event_i,
	input wire logic gpio_pin0_event_i,
	output logic [15:0] cpu_int_o,
	output logic [3:0] top_line_o,
	output logic any_line_o,
	output logic irq_o
);
	typedef struct packed {
		logic [31:0] sel_high;
		logic [31:0] sel_low;
		logic global_irq_enable;
		logic [3:0] pol;
		logic [15:4] line_en;
		logic [15:4] status;
		logic [15:4] mask;
		logic [15:0] lines;
		logic [3:0] top_line;
		logic any_line;
		logic irq;
		logic [31:0] rdata;
	} iss_state_type;

	iss_state_type state_q;
	iss_state_type state_d;
	logic [16:0] events;
	logic [15:4] selected;

	iss_edge_if edge_if ();

	assign edge_if.pin = external_irq_pin_i;
	assign edge_if.polarity = state_q.pol;

	iss_pin_edge u_pin_edge (
		.clock_i(clock_i),
		.srst_i(srst_i),
		.edge_if(edge_if)
	);

	// event vector indexed by selector code, code 0 left empty
	assign events = {gpio_pin0_event_i, serial1_receive_event_i, serial1_transmit_event_i,
		serial0_receive_event_i, serial0_transmit_event_i, emulation_tx_event_i,
		emulation_rx_event_i, emulation_dma_event_i, transfer_engine_done_event_i,
		edge_if.event_pulse, memory_interface_event_i, timer1_event_i, timer0_event_i, 1'b0};

	// unassigned codes fall through to zero so the line never fires
	function automatic logic pick_event(input logic [4:0] code, input logic [16:0] ev);
		pick_event = (code < 5'(iss_pkg::NUM_CODES)) ? ev[code] : 1'b0;
	endfunction

	// lowest set index wins, line 0 highest
	function automatic logic [3:0] prio_encode(input logic [15:0] v);
		prio_encode = 4'h0;
		for (int i = 15; i >= 0; i--) begin
			if (v[i]) begin
				prio_encode = 4'(i);
			end
		end
	endfunction

	function automatic logic [31:0] sel_write(input logic [31:0] d);
		sel_write = d & iss_pkg::SEL_WMASK;
	endfunction

	always_comb begin
		state_d = state_q;
		// route each maskable line through its selector field
		for (int i = 0; i < 6; i++) begin
			selected[4 + i] = pick_event(state_q.sel_low[iss_pkg::FIELD_POS[i] +: 5], events);
			selected[10 + i] = pick_event(state_q.sel_high[iss_pkg::FIELD_POS[i] +: 5], events);
		end
		// fixed lines bypass enable and global gate
		state_d.lines[0] = reset_event_i;
		state_d.lines[1] = nmi_event_i;
		state_d.lines[3:2] = 2'h0;
		// global enable gates every maskable line
		state_d.lines[15:4] = state_q.global_irq_enable ? (selected & state_q.line_en) : 12'h000;
		state_d.top_line = prio_encode(state_d.lines);
		state_d.any_line = |state_d.lines;
		state_d.rdata = 32'h00000000;
		if (rd_i) begin
			case (addr_i)
				iss_pkg::ADDR_SEL_HIGH: state_d.rdata = state_q.sel_high;
				iss_pkg::ADDR_SEL_LOW: state_d.rdata = state_q.sel_low;
				iss_pkg::ADDR_CTRL: begin
					state_d.rdata[iss_pkg::CTRL_GIE_BIT] = state_q.global_irq_enable;
					state_d.rdata[iss_pkg::CTRL_POL_LSB +: 4] = state_q.pol;
				end
				iss_pkg::ADDR_LINE_EN: state_d.rdata[15:4] = state_q.line_en;
				iss_pkg::ADDR_STATUS: state_d.rdata[15:4] = state_q.status;
				iss_pkg::ADDR_MASK: state_d.rdata[15:4] = state_q.mask;
				default: state_d.rdata = 32'h00000000;
			endcase
		end
		// raw selected events are recorded even while lines are gated off
		state_d.status = state_q.status | selected;
		if (wr_i) begin
			case (addr_i)
				iss_pkg::ADDR_SEL_HIGH: state_d.sel_high = sel_write(wdata_i);
				iss_pkg::ADDR_SEL_LOW: state_d.sel_low = sel_write(wdata_i);
				iss_pkg::ADDR_CTRL: begin
					state_d.global_irq_enable = wdata_i[iss_pkg::CTRL_GIE_BIT];
					state_d.pol = wdata_i[iss_pkg::CTRL_POL_LSB +: 4];
				end
				iss_pkg::ADDR_LINE_EN: state_d.line_en = wdata_i[15:4];
				// a new event in the clearing cycle survives
				iss_pkg::ADDR_STATUS: state_d.status = (state_q.status & ~wdata_i[15:4]) | selected;
				iss_pkg::ADDR_MASK: state_d.mask = wdata_i[15:4];
				default: state_d.mask = state_q.mask;
			endcase
		end
		state_d.irq = |(state_d.status & state_d.mask);
	end

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			state_q <= '0;
			state_q.sel_high <= iss_pkg::SEL_HIGH_RESET;
			state_q.sel_low <= iss_pkg::SEL_LOW_RESET;
			state_q.global_irq_enable <= 1'b0;
		end else begin
			state_q <= state_d;
		end
	end

	assign cpu_int_o = state_q.lines;
	assign top_line_o = state_q.top_line;
	assign any_line_o = state_q.any_line;
	assign irq_o = state_q.irq;
	assign rdata_o = state_q.rdata;

	property p_fixed_reserved;
		@(posedge clock_i) disable iff (srst_i)
		cpu_int_o[3:2] == 2'h0;
	endproperty
	a_fixed_reserved: assert property (p_fixed_reserved)
		else $error("reserved line driven");

	property p_reset_line;
		@(posedge clock_i) disable iff (srst_i)
		reset_event_i && !state_q.global_irq_enable |=> cpu_int_o[0];
	endproperty
	a_reset_line: assert property (p_reset_line)
		else $error("reset line not taken with global enable clear");

	property p_gie_gate;
		@(posedge clock_i) disable iff (srst_i)
		!state_q.global_irq_enable |=> cpu_int_o[15:4] == 12'h000;
	endproperty
	a_gie_gate: assert property (p_gie_gate)
		else $error("maskable line passed while globally disabled");

	property p_sel_reset;
		@(posedge clock_i)
		$past(srst_i) && !srst_i |-> state_q.sel_low == iss_pkg::SEL_LOW_RESET
			&& state_q.sel_high == iss_pkg::SEL_HIGH_RESET && cpu_int_o == 16'h0000
			&& irq_o == 1'b0 && rdata_o == 32'h00000000;
	endproperty
	a_sel_reset: assert property (p_sel_reset)
		else $error("selector reset value wrong");

	property p_sel_after_reset;
		@(posedge clock_i)
		srst_i ##1 !srst_i |-> state_q.sel_low[4:0] == 5'h04 && state_q.sel_low[30:26] == 5'h09
			&& state_q.sel_high[4:0] == 5'h03 && state_q.sel_high[20:16] == 5'h00
			&& state_q.sel_high[30:26] == 5'h02 && !state_q.global_irq_enable;
	endproperty
	a_sel_after_reset: assert property (p_sel_after_reset)
		else $error("selector fields not at reset codes");

	property p_low_route;
		@(posedge clock_i) disable iff (srst_i)
		state_q.sel_low[4:0] == 5'h01 && timer0_event_i && state_q.global_irq_enable && state_q.line_en[4]
			|=> cpu_int_o[4];
	endproperty
	a_low_route: assert property (p_low_route)
		else $error("timer 0 not routed to line 4");

	property p_high_route;
		@(posedge clock_i) disable iff (srst_i)
		state_q.sel_high[30:26] == 5'h10 && gpio_pin0_event_i && state_q.global_irq_enable
			&& state_q.line_en[15] |=> cpu_int_o[15];
	endproperty
	a_high_route: assert property (p_high_route)
		else $error("gpio 0 not routed to line 15");

	property p_unassigned;
		@(posedge clock_i) disable iff (srst_i)
		state_q.sel_low[4:0] == 5'h00 || state_q.sel_low[4:0] > 5'h10 |=> !cpu_int_o[4];
	endproperty
	a_unassigned: assert property (p_unassigned)
		else $error("unassigned code fired a line");

	property p_priority;
		@(posedge clock_i) disable iff (srst_i)
		cpu_int_o[1] |-> top_line_o <= 4'h1 && any_line_o;
	endproperty
	a_priority: assert property (p_priority)
		else $error("priority encoding wrong");

	property p_pin_edge;
		@(posedge clock_i) disable iff (srst_i)
		($rose(external_irq_pin_i[0]) && !state_q.pol[0]) ##1
			(state_q.sel_low[4:0] == 5'h04 && state_q.global_irq_enable && state_q.line_en[4]) |=> cpu_int_o[4];
	endproperty
	a_pin_edge: assert property (p_pin_edge)
		else $error("pin 4 rising edge lost");

	property p_read_high;
		@(posedge clock_i) disable iff (srst_i)
		rd_i && addr_i == 32'h019C0000 && !wr_i |=> rdata_o == $past(state_q.sel_high);
	endproperty
	a_read_high: assert property (p_read_high)
		else $error("high selector read wrong");

	property p_irq_level;
		@(posedge clock_i) disable iff (srst_i)
		irq_o == |(state_q.status & state_q.mask);
	endproperty
	a_irq_level: assert property (p_irq_level)
		else $error("interrupt output disagrees with status and mask");

	property p_nmi_line;
		@(posedge clock_i) disable iff (srst_i)
		nmi_event_i |=> cpu_int_o[1];
	endproperty
	a_nmi_line: assert property (p_nmi_line)
		else $error("nonmaskable line not taken");

	property p_line_enable;
		@(posedge clock_i) disable iff (srst_i)
		!state_q.line_en[14] |=> !cpu_int_o[14];
	endproperty
	a_line_enable: assert property (p_line_enable)
		else $error("disabled line 14 passed");

	property p_top_valid;
		@(posedge clock_i) disable iff (srst_i)
		any_line_o |-> cpu_int_o[top_line_o]
			&& (cpu_int_o & ((16'h0001 << top_line_o) - 16'h0001)) == 16'h0000;
	endproperty
	a_top_valid: assert property (p_top_valid)
		else $error("top line is not the highest active line");

	property p_idle_lines;
		@(posedge clock_i) disable iff (srst_i)
		!any_line_o |-> cpu_int_o == 16'h0000 && top_line_o == 4'h0;
	endproperty
	a_idle_lines: assert property (p_idle_lines)
		else $error("idle flag disagrees with lines");

	property p_status_set;
		@(posedge clock_i) disable iff (srst_i)
		timer1_event_i && state_q.sel_high[25:21] == iss_pkg::CODE_TIMER1 |=> state_q.status[14];
	endproperty
	a_status_set: assert property (p_status_set)
		else $error("selected event did not set status");

	property p_status_sticky;
		@(posedge clock_i) disable iff (srst_i)
		state_q.status[14] && !(wr_i && addr_i == iss_pkg::ADDR_STATUS) |=> state_q.status[14];
	endproperty
	a_status_sticky: assert property (p_status_sticky)
		else $error("status bit lost without a clear");

	property p_rdata_idle;
		@(posedge clock_i) disable iff (srst_i)
		!rd_i |=> rdata_o == 32'h00000000;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data not zero outside a read");

	property p_sel_gaps;
		@(posedge clock_i) disable iff (srst_i)
		rd_i && addr_i == iss_pkg::ADDR_SEL_LOW |=> !rdata_o[15] && !rdata_o[31];
	endproperty
	a_sel_gaps: assert property (p_sel_gaps)
		else $error("unused selector bits read as one");

	property p_unassigned_high;
		@(posedge clock_i) disable iff (srst_i)
		state_q.sel_high[25:21] > 5'h10 |=> !cpu_int_o[14];
	endproperty
	a_unassigned_high: assert property (p_unassigned_high)
		else $error("unassigned code fired line 14");

	c_pin_line: cover property (@(posedge clock_i) disable iff (srst_i) cpu_int_o[4] && external_irq_pin_i[0]);
	c_top_low: cover property (@(posedge clock_i) disable iff (srst_i) cpu_int_o[15] && top_line_o == 4'hF);
	c_irq: cover property (@(posedge clock_i) disable iff (srst_i) $rose(irq_o));
	c_nmi: cover property (@(posedge clock_i) disable iff (srst_i) cpu_int_o[1] && cpu_int_o[0]);
	c_clear: cover property (@(posedge clock_i) disable iff (srst_i) $fell(irq_o));
endmodule

//--- test/iss_src_model.sv
`timescale 1ns/10ps
// event sources on the far side; each changes only just after a clock edge
module iss_src_model (
	input wire logic clock_i,
	input wire logic [16:0] req_i,
	input wire logic [3:0] pin_req_i,
	output logic [16:0] ev_o,
	output logic [3:0] pin_o
);
	always_ff @(posedge clock_i) begin
		ev_o <= req_i;
		// pins are assumed enabled and set as inputs in the pin block
		pin_o <= pin_req_i;
	end
endmodule

//--- test/testbench.sv
`timescale 1ns/10ps
module testbench;
	logic clock_i = 1'b0;
	logic srst_i = 1'b1;
	logic [31:0] addr_i = 32'h0;
	logic [31:0] wdata_i = 32'h0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic reset_ev = 1'b0;
	logic nmi_ev = 1'b0;
	logic [16:0] req = 17'h0;
	logic [3:0] pin_req = 4'h0;
	logic [16:0] ev;
	logic [3:0] pin;
	logic [31:0] rdata_o;
	logic [15:0] cpu_int_o;
	logic [3:0] top_line_o;
	logic any_line_o;
	logic irq_o;
	int error_cnt = 0;
	int checked = 0;
	logic [31:0] rv;
	int n;
	logic [15:0] seen_lines;
	iss_src_model iss_src_model_inst (.clock_i(clock_i), .req_i(req), .pin_req_i(pin_req),
		.ev_o(ev), .pin_o(pin));
	iss_top iss_top_inst (.clock_i(clock_i), .srst_i(srst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.reset_event_i(reset_ev), .nmi_event_i(nmi_ev), .timer0_event_i(ev[1]),
		.timer1_event_i(ev[2]), .memory_interface_event_i(ev[3]), .external_irq_pin_i(pin),
		.transfer_engine_done_event_i(ev[8]), .emulation_dma_event_i(ev[9]),
		.emulation_rx_event_i(ev[10]), .emulation_tx_event_i(ev[11]),
		.serial0_transmit_event_i(ev[12]), .serial0_receive_event_i(ev[13]),
		.serial1_transmit_event_i(ev[14]), .serial1_receive_event_i(ev[15]),
		.gpio_pin0_event_i(ev[16]), .cpu_int_o(cpu_int_o), .top_line_o(top_line_o),
		.any_line_o(any_line_o), .irq_o(irq_o));
	initial begin
		forever #5 clock_i = ~clock_i;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clock_i);
		#1;
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge clock_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [31:0] a);
		@(posedge clock_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clock_i);
		rd_i <= 1'b0;
		#1;
		rv = rdata_o;
	endtask
	task automatic fire(input logic [16:0] r);
		@(posedge clock_i);
		req <= r;
		cyc(4);
	endtask
	task automatic count_line(input int idx);
		n = 0;
		seen_lines = 16'h0000;
		repeat (8) begin
			cyc(1);
			seen_lines = seen_lines | cpu_int_o;
			if (cpu_int_o[idx] === 1'b1) n++;
		end
	endtask
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic t_reset;
		rd(iss_pkg::ADDR_SEL_HIGH);
		check(rv, {1'b0, 5'h02, 5'h01, 5'h00, 1'b0, 5'h0B, 5'h0A, 5'h03}, "high sel");
		rd(iss_pkg::ADDR_SEL_LOW);
		check(rv, {1'b0, 5'h09, 5'h08, 5'h07, 1'b0, 5'h06, 5'h05, 5'h04}, "low sel");
		rd(iss_pkg::ADDR_CTRL);
		check(rv, 32'h0, "ctrl");
		wr(iss_pkg::ADDR_SEL_LOW, 32'hFFFFFFFF);
		rd(iss_pkg::ADDR_SEL_LOW);
		check(rv, 32'h7FFF7FFF, "low sel fields");
		wr(32'h019C0020, 32'hFFFFFFFF);
		rd(32'h019C0020);
		check(rv, 32'h0, "unmapped");
		wr(iss_pkg::ADDR_SEL_LOW, {1'b0, 5'h09, 5'h08, 5'h07, 1'b0, 5'h06, 5'h05, 5'h04});
		$display("test reset done");
	endtask
	task automatic t_codes;
		logic [4:0] c;
		wr(iss_pkg::ADDR_CTRL, 32'h1);
		wr(iss_pkg::ADDR_LINE_EN, 32'h0000FFF0);
		for (int i = 0; i < 18; i++) begin
			c = 5'(i);
			if (i >= 4 && i <= 7) continue;
			wr(iss_pkg::ADDR_SEL_HIGH, (32'(c) << 26) | (32'(c) << 21) | 32'(c));
			if (i == 0 || i == 17) begin
				wr(iss_pkg::ADDR_SEL_LOW, {1'b0, 5'h09, 5'h08, 5'h07, 1'b0, 5'h06, 5'h05, c});
			end
			fire(i == 0 || i == 17 ? 17'h1FFFF : 17'h1 << i);
			if (i == 0 || i == 17) begin
				check(cpu_int_o[15:10], 6'h0, "no source");
				check(cpu_int_o[4], 1'b0, "no source low");
			end else begin
				check(cpu_int_o[15], 1'b1, "line 15");
				check(cpu_int_o[14], 1'b1, "line 14");
				check(cpu_int_o[10], 1'b1, "line 10");
				check(top_line_o, i == 8 ? 4'h8 : i == 9 ? 4'h9 : 4'hA, "top");
				check(any_line_o, 1'b1, "any");
			end
			fire(17'h0);
			check(cpu_int_o, 16'h0, "released");
		end
		wr(iss_pkg::ADDR_SEL_LOW, 32'h00100001);
		fire(17'h10002);
		check(cpu_int_o, 16'h0090, "lines 4 and 7");
		check(top_line_o, 4'h4, "top low");
		fire(17'h0);
		$display("test codes done");
	endtask
	task automatic t_gate;
		wr(iss_pkg::ADDR_SEL_HIGH, 32'h00400000);
		wr(iss_pkg::ADDR_CTRL, 32'h0);
		@(posedge clock_i);
		reset_ev <= 1'b1;
		nmi_ev <= 1'b1;
		fire(17'h00004);
		check(cpu_int_o, 16'h0003, "gie off");
		wr(iss_pkg::ADDR_LINE_EN, 32'h0);
		wr(iss_pkg::ADDR_CTRL, 32'h1);
		cyc(2);
		check(cpu_int_o, 16'h0003, "line disabled");
		check(top_line_o, 4'h0, "top reset");
		@(posedge clock_i);
		reset_ev <= 1'b0;
		nmi_ev <= 1'b0;
		fire(17'h0);
		$display("test gate done");
	endtask
	task automatic t_status;
		wr(iss_pkg::ADDR_STATUS, 32'h0000FFFF);
		wr(iss_pkg::ADDR_MASK, 32'h0);
		fire(17'h00004);
		fire(17'h0);
		check(irq_o, 1'b0, "masked");
		rd(iss_pkg::ADDR_STATUS);
		check(rv, 32'h00004000, "status");
		wr(iss_pkg::ADDR_MASK, 32'h00004000);
		cyc(2);
		check(irq_o, 1'b1, "irq");
		wr(iss_pkg::ADDR_STATUS, 32'h00004000);
		cyc(2);
		check(irq_o, 1'b0, "cleared");
		$display("test status done");
	endtask
	task automatic t_pins;
		wr(iss_pkg::ADDR_SEL_LOW, {1'b0, 5'h09, 5'h08, 5'h07, 1'b0, 5'h06, 5'h05, 5'h04});
		wr(iss_pkg::ADDR_LINE_EN, 32'h0000FFF0);
		@(posedge clock_i);
		pin_req <= 4'h1;
		count_line(4);
		check(32'(n), 32'd1, "rising pulse");
		check(seen_lines, 16'h0010, "rising lines");
		wr(iss_pkg::ADDR_CTRL, 32'h11);
		count_line(4);
		check(32'(n), 32'd0, "held high");
		@(posedge clock_i);
		pin_req <= 4'h0;
		count_line(4);
		check(32'(n), 32'd1, "falling pulse");
		wr(iss_pkg::ADDR_CTRL, 32'h01);
		@(posedge clock_i);
		pin_req <= 4'hE;
		count_line(7);
		check(32'(n), 32'd1, "pin 7 rising");
		check(seen_lines, 16'h00E0, "pins 5-7 rising");
		wr(iss_pkg::ADDR_CTRL, 32'hF1);
		@(posedge clock_i);
		pin_req <= 4'h0;
		count_line(7);
		check(seen_lines, 16'h00E0, "pins 5-7 falling");
		$display("test pins done");
	endtask
	task automatic t_midreset;
		wr(iss_pkg::ADDR_CTRL, 32'h1);
		@(posedge clock_i);
		srst_i <= 1'b1;
		repeat (2) @(posedge clock_i);
		srst_i <= 1'b0;
		cyc(1);
		check(cpu_int_o, 16'h0, "reset idle");
		rd(iss_pkg::ADDR_CTRL);
		check(rv, 32'h0, "gie after reset");
		rd(iss_pkg::ADDR_SEL_HIGH);
		check(rv, {1'b0, 5'h02, 5'h01, 5'h00, 1'b0, 5'h0B, 5'h0A, 5'h03}, "high again");
		$display("test midreset done");
	endtask
	initial begin
		repeat (10) @(posedge clock_i);
		srst_i <= 1'b0;
		cyc(1);
		check(cpu_int_o, 16'h0, "idle");
		t_reset();
		t_codes();
		t_gate();
		t_status();
		t_pins();
		t_midreset();
		complete_run();
	end
	initial begin
		repeat (20000) @(posedge clock_i);
		error_cnt++;
		$display("unexpected at %0t: run limit reached", $time);
		complete_run();
	end
endmodule
